// File: dv/test_vpam_plane_access_mapper.sv
`timescale 1ns/1ns
module test_vpam_plane_access_mapper
	import vpam_pkg::*;
;
	logic            mclk, nrst, io_req, io_we, io_rvalid;
	logic            mem_rvalid, mem_blocked;
	logic [15:0]     io_addr;
	logic [7:0]      io_wdata, io_rdata, mem_rdata, d, m;
	logic [7:0]      v [4];
	logic [5:0]      font_eff;
	logic [31:0]     plane_rdata;
	logic [8:0]      exp_q [$];
	vpam_host_mem_t  host_mem;
	vpam_plane_req_t plane_req;
	int              error_cnt, checks_done, seed, cyc;

	vpam_top dut_u (.mclk(mclk), .nrst(nrst), .io_req(io_req),
		.io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid),
		.host_mem(host_mem), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid), .mem_blocked(mem_blocked),
		.plane_req(plane_req), .plane_rdata(plane_rdata),
		.font_select_eff(font_eff));
	vpam_plane_mem mem_u (.mclk(mclk), .plane_req(plane_req),
		.plane_rdata(plane_rdata));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [8:0] e, g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// ----
	// result watcher
	// ----
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up();
		end else if (nrst
			&& {io_rvalid, mem_rvalid, mem_blocked} !== 3'h0) begin
			if (exp_q.size() == 0)
				chk("stray result", 9'h000, 9'h1FF);
			else
				chk("result", exp_q.pop_front(),
					{mem_blocked, io_rvalid ? io_rdata : mem_rdata});
		end
	end

	// ----
	// host tasks
	// ----
	task automatic io(input logic w, input logic [15:0] a,
		input logic [7:0] dd);
		if (!w)
			exp_q.push_back({1'h0, dd});
		io_req   <= 1'h1;
		io_we    <= w;
		io_addr  <= a;
		io_wdata <= w ? dd : 8'h00;
		@(posedge mclk);
		io_req <= 1'h0;
		@(posedge mclk);
	endtask : io

	task automatic rg(input logic g, w, input logic [7:0] i, vv);
		io(1, g ? VPAM_PORT_GFX_INDEX : VPAM_PORT_SEQ_INDEX, i);
		io(w, g ? VPAM_PORT_GFX_DATA : VPAM_PORT_SEQ_DATA, vv);
	endtask : rg

	task automatic mem(input logic w, pg, input logic [17:0] a,
		input logic [7:0] dd, input logic [8:0] e);
		if (!w || e[8])
			exp_q.push_back(e);
		host_mem <= '{1'h1, w, pg, a, dd};
		@(posedge mclk);
		host_mem.req <= 1'h0;
		repeat (4) @(posedge mclk);
	endtask : mem

	task automatic rd4(input logic [15:0] b);
		for (int p = 0; p < 4; p++)
			mem(0, 0, {b, 2'(p)}, 8'h00, {1'h0, v[p]});
	endtask : rd4

	initial begin
		{nrst, io_req, io_we, io_addr, io_wdata} = '0;
		host_mem = '0;
		{error_cnt, checks_done, cyc} = '0;
		seed = 88;
		repeat (4) @(posedge mclk);
		nrst <= 1'h1;
		repeat (3) @(posedge mclk);
		rg(0, 0, 8'h04, 8'h00);
		rg(0, 0, 8'h07, 8'h00);
		rg(1, 0, 8'h08, 8'hFF);
		rg(0, 1, 8'h04, 8'hFF);
		rg(0, 0, 8'h04, 8'h0E);
		rg(0, 1, 8'h02, 8'hFF);
		rg(0, 0, 8'h02, 8'h0F);
		rg(0, 1, 8'h03, 8'hFF);
		rg(0, 0, 8'h03, 8'h3F);
		rg(0, 1, 8'h07, 8'h5A);
		rg(1, 1, 8'h00, 8'hFF);
		rg(1, 0, 8'h00, 8'h0F);
		io(1, VPAM_PORT_GFX_INDEX, 8'hFF);
		io(0, VPAM_PORT_GFX_INDEX, 8'h1F);
		chk("font map", 9'h03F, {3'h0, font_eff});
		// chain mapping, write mask gating
		rg(1, 1, 8'h01, 8'h00);
		for (int p = 0; p < 4; p++) begin
			v[p] = 8'($random(seed));
			mem(1, 0, {16'h8004, 2'(p)}, v[p], 9'h000);
		end
		rg(0, 1, 8'h02, 8'h05);
		mem(1, 0, {16'h8004, 2'h1}, ~v[1], 9'h000);
		rd4(16'h8004);
		// write mode 0 fill
		rg(1, 1, 8'h00, 8'h05);
		rg(1, 1, 8'h01, 8'h03);
		rg(0, 1, 8'h02, 8'h0F);
		d = 8'($random(seed));
		for (int p = 0; p < 4; p++)
			mem(1, 0, {16'h8004, 2'(p)}, d, 9'h000);
		v = '{8'hFF, 8'h00, d, d};
		rd4(16'h8004);
		// write mode 3 with rotation
		rg(1, 1, 8'h03, 8'h03);
		rg(1, 1, 8'h05, 8'h03);
		rg(1, 1, 8'h08, 8'h3C);
		d = 8'($random(seed));
		m = 8'({d, d} >> 3) & 8'h3C;
		for (int p = 0; p < 4; p++) begin
			mem(1, 0, {16'h8004, 2'(p)}, d, 9'h000);
			v[p] = (v[p] & ~m) | ({8{p[0] == 1'h0}} & m);
		end
		rd4(16'h8004);
		rg(1, 1, 8'h03, 8'h00);
		rg(1, 1, 8'h05, 8'h00);
		rg(1, 1, 8'h08, 8'hFF);
		// alternating, paged and sequential mapping
		rg(1, 1, 8'h01, 8'h00);
		rg(0, 1, 8'h04, 8'h02);
		mem(1, 0, 18'h00021, d, 9'h000);
		mem(1, 1, 18'h00031, ~d, 9'h000);
		rg(0, 1, 8'h04, 8'h06);
		rg(0, 1, 8'h02, 8'h04);
		mem(1, 0, 18'h00050, d ^ 8'h55, 9'h000);
		rg(0, 1, 8'h04, 8'h0A);
		v = '{8'h00, d, 8'h00, d};
		rd4(16'h0010);
		v = '{~d, ~d, ~d, ~d};
		rd4(16'h0031);
		v = '{8'h00, 8'h00, d ^ 8'h55, 8'h00};
		rd4(16'h0050);
		// 64KB limit
		rg(0, 1, 8'h04, 8'h08);
		mem(1, 0, 18'h10000, d, 9'h100);
		mem(0, 0, 18'h3FFFF, 8'h00, 9'h100);
		mem(0, 0, 18'h00041, 8'h00, {1'h0, d});
		chk("font map", 9'h000, {3'h0, font_eff});
		rg(0, 0, 8'h07, 8'h5A);
		repeat (4) @(posedge mclk);
		chk("queue", 9'h000, 9'(exp_q.size()));
		wrap_up();
	end
endmodule : test_vpam_plane_access_mapper

// File: dv/vpam_plane_mem.sv
`timescale 1ns/1ns
module vpam_plane_mem
	import vpam_pkg::*;
(
	// clock
	input  wire logic                mclk,
	// plane port
	input  vpam_pkg::vpam_plane_req_t plane_req,
	output logic [31:0]              plane_rdata
);
	logic [31:0] mem [logic [15:0]];
	logic [31:0] cur;
	logic [7:0]  bm;

	initial plane_rdata = 32'h0;
	// ----
	// bit-masked planes, written on the rising edge
	// ----
	always @(posedge mclk) begin
		cur = mem.exists(plane_req.addr) ? mem[plane_req.addr] : 32'h0;
		bm = plane_req.bit_mask;
		if (plane_req.req && plane_req.we) begin
			for (int p = 0; p < 4; p++)
				if (plane_req.plane_en[p])
					cur[p*8+:8] = (cur[p*8+:8] & ~bm)
						| (plane_req.wdata[p*8+:8] & bm);
			mem[plane_req.addr] = cur;
		end
	end

	// ----
	// read data settles mid-cycle so it stands at the edge that
	// ends the plane request; garbage while no read is pending
	// ----
	always @(negedge mclk) begin
		if (plane_req.req && !plane_req.we)
			plane_rdata <= mem.exists(plane_req.addr)
				? mem[plane_req.addr] : 32'h0;
		else
			plane_rdata <= ~plane_rdata;
	end
endmodule : vpam_plane_mem

// File: dv/vpam_top_monitor.sv
`timescale 1ns/1ns
module vpam_top_monitor
	import vpam_pkg::*;
(
	// clock and reset
	input wire logic                mclk,
	input wire logic                nrst,
	// register port
	input wire logic                io_req,
	input wire logic                io_we,
	input wire logic [15:0]         io_addr,
	input wire logic [7:0]          io_wdata,
	input wire logic [7:0]          io_rdata,
	// memory path
	input vpam_pkg::vpam_host_mem_t  host_mem,
	input wire logic                mem_rvalid,
	input wire logic                mem_blocked,
	input vpam_pkg::vpam_plane_req_t plane_req,
	input wire logic [5:0]          font_select_eff
);
	logic [2:0] sidx;
	logic [3:1] mm;
	logic [3:0] wm;
	wire        ok = mm[1] || host_mem.addr[17:16] == 2'h0;
	wire        wr = io_req && io_we;

	// ----
	// mirror of mode bits
	// ----
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sidx <= 3'h0;
			mm   <= 3'h0;
			wm   <= 4'h0;
		end else if (wr && io_addr == VPAM_PORT_SEQ_INDEX) begin
			sidx <= io_wdata[2:0];
		end else if (wr && io_addr == VPAM_PORT_SEQ_DATA) begin
			if (sidx == VPAM_SEQ_MEM_MODE)
				mm <= io_wdata[3:1];
			if (sidx == VPAM_SEQ_PLANE_MASK)
				wm <= io_wdata[3:0];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence h_wr;
		host_mem.req && host_mem.we && ok;
	endsequence
	sequence p_wr;
		plane_req.req && plane_req.we;
	endsequence
	sequence p_rd;
		plane_req.req && !plane_req.we && plane_req.plane_en == 4'h0;
	endsequence

	gfx_index_a: assert property (io_req && !io_we &&
		io_addr == VPAM_PORT_GFX_INDEX |=> io_rdata[7:5] == 3'h0)
		else $error("index upper bits set");
	chain_map_a: assert property (h_wr ##0 mm[3] |=> p_wr ##0
		(plane_req.plane_en == ((4'h1 << $past(host_mem.addr[1:0])) & wm)
		&& plane_req.addr == $past(host_mem.addr[17:2])))
		else $error("chain mapping wrong");
	odd_even_a: assert property (h_wr ##0 (!mm[3] && !mm[2] &&
		!host_mem.paged) |=> p_wr ##0 (plane_req.plane_en ==
		(($past(host_mem.addr[0]) ? 4'hA : 4'h5) & wm)
		&& plane_req.addr == $past(host_mem.addr[16:1])))
		else $error("alternating mapping wrong");
	seq_map_a: assert property (h_wr ##0 (!mm[3] &&
		(mm[2] || host_mem.paged)) |=> p_wr ##0 (plane_req.plane_en == wm
		&& plane_req.addr == $past(host_mem.addr[15:0])))
		else $error("sequential mapping wrong");
	extent_block_a: assert property (host_mem.req && !ok
		|=> mem_blocked && !plane_req.req)
		else $error("access beyond limit let through");
	block_src_a: assert property (mem_blocked
		|-> $past(host_mem.req && !ok))
		else $error("spurious block");
	read_flow_a: assert property (host_mem.req && !host_mem.we && ok
		|=> p_rd ##1 mem_rvalid)
		else $error("read flow wrong");
	font_gate_a: assert property ((!mm[1]) [*3]
		|-> font_select_eff == 6'h00)
		else $error("font map active without extension");
endmodule : vpam_top_monitor

bind vpam_top vpam_top_monitor mon_u (.mclk(mclk), .nrst(nrst),
	.io_req(io_req), .io_we(io_we), .io_addr(io_addr),
	.io_wdata(io_wdata), .io_rdata(io_rdata), .host_mem(host_mem),
	.mem_rvalid(mem_rvalid), .mem_blocked(mem_blocked),
	.plane_req(plane_req), .font_select_eff(font_select_eff));

// File: hdl/vpam_pkg.sv
package vpam_pkg;

	// ---------------------------------------------------------------
	// i/o ports
	// ---------------------------------------------------------------
	localparam logic [15:0] VPAM_PORT_SEQ_INDEX = 16'h03C4;
	localparam logic [15:0] VPAM_PORT_SEQ_DATA  = 16'h03C5;
	localparam logic [15:0] VPAM_PORT_GFX_INDEX = 16'h03CE;
	localparam logic [15:0] VPAM_PORT_GFX_DATA  = 16'h03CF;

	// ---------------------------------------------------------------
	// sequencer and graphics indexes
	// ---------------------------------------------------------------
	localparam logic [2:0] VPAM_SEQ_PLANE_MASK = 3'h2;
	localparam logic [2:0] VPAM_SEQ_FONT       = 3'h3;
	localparam logic [2:0] VPAM_SEQ_MEM_MODE   = 3'h4;
	localparam logic [2:0] VPAM_SEQ_CHAR_HOLD  = 3'h7;
	localparam logic [4:0] VPAM_GFX_FILL_VAL   = 5'h00;
	localparam logic [4:0] VPAM_GFX_FILL_EN    = 5'h01;
	localparam logic [4:0] VPAM_GFX_ROTATE     = 5'h03;
	localparam logic [4:0] VPAM_GFX_MODE       = 5'h05;
	localparam logic [4:0] VPAM_GFX_BIT_MASK   = 5'h08;

	// ---------------------------------------------------------------
	// field layouts and reset values
	// ---------------------------------------------------------------
	localparam int          VPAM_MM_EXT_BIT   = 1;
	localparam int          VPAM_MM_ODDEV_BIT = 2;
	localparam int          VPAM_MM_CHAIN_BIT = 3;
	localparam logic [7:0]  VPAM_MM_WMASK     = 8'h0E;
	localparam logic [7:0]  VPAM_NIBBLE_WMASK = 8'h0F;
	localparam logic [7:0]  VPAM_FONT_WMASK   = 8'h3F;
	localparam logic [7:0]  VPAM_ROT_WMASK    = 8'h07;
	localparam logic [7:0]  VPAM_MODE_WMASK   = 8'h03;
	localparam logic [7:0]  VPAM_GFX_IDX_WMASK = 8'h1F;
	localparam logic [7:0]  VPAM_REG_RESET    = 8'h00;
	localparam logic [7:0]  VPAM_BITMASK_RESET = 8'hFF;
	localparam logic [7:0]  VPAM_ALL_BITS     = 8'hFF;

	// ---------------------------------------------------------------
	// write modes and memory extent
	// ---------------------------------------------------------------
	localparam logic [1:0]  VPAM_WMODE_0 = 2'h0;
	localparam logic [1:0]  VPAM_WMODE_3 = 2'h3;
	localparam int          VPAM_HOST_AW  = 18;
	localparam int          VPAM_PLANE_AW = 16;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                    req;
		logic                    we;
		logic                    paged;
		logic [VPAM_HOST_AW-1:0] addr;
		logic [7:0]              wdata;
	} vpam_host_mem_t;

	typedef struct packed {
		logic                     req;
		logic                     we;
		logic [3:0]               plane_en;
		logic [VPAM_PLANE_AW-1:0] addr;
		logic [7:0]               bit_mask;
		logic [31:0]              wdata;
	} vpam_plane_req_t;

	typedef struct packed {
		logic [3:0]               plane_en;
		logic [1:0]               read_plane;
		logic [VPAM_PLANE_AW-1:0] addr;
		logic                     blocked;
	} vpam_route_t;

endpackage : vpam_pkg

// File: hdl/vpam_plane_route.sv
`timescale 1ns/1ns
module vpam_plane_route
	import vpam_pkg::*;
(
	// host access
	input  wire logic [VPAM_HOST_AW-1:0] addr,
	input  wire logic                    paged,
	// mode bits
	input  wire logic [7:0]              mem_mode,
	input  wire logic [3:0]              plane_write_mask,
	// result
	output vpam_pkg::vpam_route_t        route
);
	import vpam_pkg::*;

	logic chain;
	logic odd_even;

	assign chain    = mem_mode[VPAM_MM_CHAIN_BIT];
	// alternating planes only for non-paged accesses without chain
	assign odd_even = !chain && !mem_mode[VPAM_MM_ODDEV_BIT] && !paged;

	always_comb begin
		route.blocked = !mem_mode[VPAM_MM_EXT_BIT]
			&& (addr[VPAM_HOST_AW-1:VPAM_PLANE_AW] != '0);
		if (chain) begin
			route.read_plane = addr[1:0];
			route.plane_en   = (4'h1 << addr[1:0]) & plane_write_mask;
			route.addr       = addr[VPAM_PLANE_AW+1:2];
		end else if (odd_even) begin
			route.read_plane = {1'b0, addr[0]};
			route.plane_en   = (addr[0] ? 4'hA : 4'h5)
				& plane_write_mask;
			route.addr       = addr[VPAM_PLANE_AW:1];
		end else begin
			route.read_plane = 2'h0;
			route.plane_en   = plane_write_mask;
			route.addr       = addr[VPAM_PLANE_AW-1:0];
		end
	end

endmodule : vpam_plane_route

// File: hdl/vpam_top.sv
`timescale 1ns/1ns
module vpam_top
	import vpam_pkg::*;
(
	// clock and reset
	input  wire logic            mclk,
	input  wire logic            nrst,
	// host i/o port
	input  wire logic            io_req,
	input  wire logic            io_we,
	input  wire logic [15:0]     io_addr,
	input  wire logic [7:0]      io_wdata,
	output logic [7:0]           io_rdata,
	output logic                 io_rvalid,
	// host memory access
	input  vpam_pkg::vpam_host_mem_t host_mem,
	output logic [7:0]           mem_rdata,
	output logic                 mem_rvalid,
	output logic                 mem_blocked,
	// plane memory
	output vpam_pkg::vpam_plane_req_t plane_req,
	input  wire logic [31:0]     plane_rdata,
	// font selection to the character generator
	output logic [5:0]           font_select_eff
);
	import vpam_pkg::*;

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic       rst_meta;
	logic       rst_n;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [2:0] sequencer_index_select;
	logic [7:0] plane_write_mask;
	logic [7:0] font_select;
	logic [7:0] memory_mapping_mode;
	logic [7:0] char_counter_hold;
	logic [7:0] graphics_index_select;
	logic [7:0] plane_fill_value;
	logic [7:0] plane_fill_enable;
	logic [7:0] rotate_count;
	logic [7:0] graph_mode_control;
	logic [7:0] pixel_bit_mask;

	logic seq_wr;
	logic gfx_wr;
	assign seq_wr = io_req && io_we && (io_addr == VPAM_PORT_SEQ_DATA);
	assign gfx_wr = io_req && io_we && (io_addr == VPAM_PORT_GFX_DATA);

	function automatic logic [7:0] rotr(input logic [7:0] d,
		input logic [2:0] n);
		logic [15:0] t;
		t = {d, d} >> n;
		return t[7:0];
	endfunction : rotr

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sequencer_index_select <= '0;
			graphics_index_select  <= VPAM_REG_RESET;
		end else if (io_req && io_we) begin
			if (io_addr == VPAM_PORT_SEQ_INDEX)
				sequencer_index_select <= io_wdata[2:0];
			if (io_addr == VPAM_PORT_GFX_INDEX)
				graphics_index_select <= io_wdata & VPAM_GFX_IDX_WMASK;
		end
	end

	// sequencer data port; writes here never restart counters
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			plane_write_mask    <= VPAM_REG_RESET;
			font_select         <= VPAM_REG_RESET;
			memory_mapping_mode <= VPAM_REG_RESET;
			char_counter_hold   <= VPAM_REG_RESET;
		end else if (seq_wr) begin
			unique case (sequencer_index_select)
				VPAM_SEQ_PLANE_MASK: plane_write_mask <=
					io_wdata & VPAM_NIBBLE_WMASK;
				VPAM_SEQ_FONT: font_select <= io_wdata & VPAM_FONT_WMASK;
				VPAM_SEQ_MEM_MODE: memory_mapping_mode <=
					io_wdata & VPAM_MM_WMASK;
				VPAM_SEQ_CHAR_HOLD: char_counter_hold <= io_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			plane_fill_value   <= VPAM_REG_RESET;
			plane_fill_enable  <= VPAM_REG_RESET;
			rotate_count       <= VPAM_REG_RESET;
			graph_mode_control <= VPAM_REG_RESET;
			pixel_bit_mask     <= VPAM_BITMASK_RESET;
		end else if (gfx_wr) begin
			unique case (graphics_index_select[4:0])
				VPAM_GFX_FILL_VAL: plane_fill_value <=
					io_wdata & VPAM_NIBBLE_WMASK;
				VPAM_GFX_FILL_EN: plane_fill_enable <=
					io_wdata & VPAM_NIBBLE_WMASK;
				VPAM_GFX_ROTATE: rotate_count <= io_wdata & VPAM_ROT_WMASK;
				VPAM_GFX_MODE: graph_mode_control <=
					io_wdata & VPAM_MODE_WMASK;
				VPAM_GFX_BIT_MASK: pixel_bit_mask <= io_wdata;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// register read back
	// ---------------------------------------------------------------
	logic [7:0] next_io_rdata;

	always_comb begin
		next_io_rdata = '0;
		unique case (io_addr)
			VPAM_PORT_SEQ_INDEX: next_io_rdata = {5'h00,
				sequencer_index_select};
			VPAM_PORT_SEQ_DATA: begin
				unique case (sequencer_index_select)
					VPAM_SEQ_PLANE_MASK: next_io_rdata = plane_write_mask;
					VPAM_SEQ_FONT: next_io_rdata = font_select;
					VPAM_SEQ_MEM_MODE: next_io_rdata = memory_mapping_mode;
					VPAM_SEQ_CHAR_HOLD: next_io_rdata = char_counter_hold;
					default: next_io_rdata = '0;
				endcase
			end
			VPAM_PORT_GFX_INDEX: next_io_rdata = graphics_index_select;
			VPAM_PORT_GFX_DATA: begin
				unique case (graphics_index_select[4:0])
					VPAM_GFX_FILL_VAL: next_io_rdata = plane_fill_value;
					VPAM_GFX_FILL_EN: next_io_rdata = plane_fill_enable;
					VPAM_GFX_ROTATE: next_io_rdata = rotate_count;
					VPAM_GFX_MODE: next_io_rdata = graph_mode_control;
					VPAM_GFX_BIT_MASK: next_io_rdata = pixel_bit_mask;
					default: next_io_rdata = '0;
				endcase
			end
			default: next_io_rdata = '0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata  <= '0;
			io_rvalid <= 1'b0;
		end else begin
			io_rvalid <= io_req && !io_we;
			io_rdata  <= (io_req && !io_we) ? next_io_rdata : '0;
		end
	end

	// ---------------------------------------------------------------
	// font selection
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			font_select_eff <= '0;
		else if (memory_mapping_mode[VPAM_MM_EXT_BIT])
			font_select_eff <= font_select[5:0];
		else
			font_select_eff <= '0;
	end

	// ---------------------------------------------------------------
	// frame buffer access
	// ---------------------------------------------------------------
	vpam_route_t route;

	vpam_plane_route u_route (
		.addr             (host_mem.addr),
		.paged            (host_mem.paged),
		.mem_mode         (memory_mapping_mode),
		.plane_write_mask (plane_write_mask[3:0]),
		.route            (route)
	);

	logic [31:0] next_wdata;
	logic [7:0]  next_mask;
	logic [1:0]  wmode;
	logic        go;

	assign wmode = graph_mode_control[1:0];
	assign go    = host_mem.req && !route.blocked;

	always_comb begin
		next_mask = VPAM_ALL_BITS;
		for (int p = 0; p < 4; p++) begin
			next_wdata[p*8 +: 8] = host_mem.wdata;
			if (wmode == VPAM_WMODE_0 && plane_fill_enable[p])
				next_wdata[p*8 +: 8] = {8{plane_fill_value[p]}};
			else if (wmode == VPAM_WMODE_3)
				next_wdata[p*8 +: 8] = {8{plane_fill_value[p]}};
		end
		if (wmode == VPAM_WMODE_0)
			next_mask = pixel_bit_mask;
		else if (wmode == VPAM_WMODE_3)
			next_mask = rotr(host_mem.wdata, rotate_count[2:0])
				& pixel_bit_mask;
	end

	logic       rd_pend;
	logic [1:0] rd_plane;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			plane_req   <= '0;
			mem_blocked <= 1'b0;
			rd_pend     <= 1'b0;
			rd_plane    <= '0;
		end else begin
			plane_req.req      <= go;
			plane_req.we       <= go && host_mem.we;
			plane_req.plane_en <= (go && host_mem.we) ? route.plane_en
				: '0;
			plane_req.addr     <= route.addr;
			plane_req.bit_mask <= next_mask;
			plane_req.wdata    <= next_wdata;
			mem_blocked        <= host_mem.req && route.blocked;
			rd_pend            <= go && !host_mem.we;
			rd_plane           <= route.read_plane;
		end
	end

	// read data arrives one cycle after the plane request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rdata  <= '0;
			mem_rvalid <= 1'b0;
		end else begin
			mem_rvalid <= rd_pend;
			mem_rdata  <= rd_pend ? plane_rdata[rd_plane*8 +: 8] : '0;
		end
	end

endmodule : vpam_top
